// ### sfr_board_model.sv
// Board-side partner of the reset sequencer: global reset driver and PLL model.
// Assumes the bench steers it through hold_reset and block_lock on pclk.
module sfr_board_model
    import sfr_pkg::*;
#(
    parameter int LOCK_DLY = 8
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bench controls.
    input wire logic hold_reset,
    input wire logic block_lock,
    // Device side.
    input wire logic pll_init,
    output logic global_reset_n,
    output logic pll_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lock_cnt_q;

    // The PLL locks a fixed time after init starts, unless the bench stalls it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_reset_n <= 1'b0;
            lock_cnt_q <= 8'h00;
            pll_lock <= 1'b0;
        end else begin
            global_reset_n <= !hold_reset;
            if (hold_reset || block_lock) begin
                lock_cnt_q <= 8'h00;
                pll_lock <= 1'b0;
            end else if (pll_init && lock_cnt_q < LOCK_DLY) begin
                lock_cnt_q <= lock_cnt_q + 8'h01;
            end else if (lock_cnt_q >= LOCK_DLY) begin
                pll_lock <= 1'b1;
            end
        end
    end
endmodule

// ### sfr_pkg.sv
// Package for the switch fundamental reset sequencer: register map,
// field positions, reset values, timing constants, state and strap types.
// Assumes a 100 MHz APB clock and one design module that imports it.
package sfr_pkg;

    // Register byte offsets.
    localparam logic [11:0] SFR_CTRL_OFS = 12'h000;
    localparam logic [11:0] SFR_BOOT_OFS = 12'h004;
    localparam logic [11:0] SFR_SEQ_OFS = 12'h008;

    // Switch control register fields.
    localparam int SFR_UNLOCK_BIT = 0;
    localparam int SFR_HALT_BIT = 1;

    // Sequence status register fields.
    localparam int SFR_SEQ_STATE_LSB = 0;
    localparam int SFR_SEQ_PLL_BIT = 4;
    localparam int SFR_SEQ_STACK_BIT = 5;
    localparam int SFR_SEQ_READY_BIT = 6;
    localparam int SFR_SEQ_QUASI_BIT = 7;
    localparam int SFR_SEQ_RUN_BIT = 8;

    // Timing: the figures in milliseconds and the clock rate.
    localparam int SFR_CLK_MHZ = 100;
    localparam int SFR_STACK_DEADLINE_MS = 20;
    localparam int SFR_READY_DEADLINE_MS = 100;
    localparam int SFR_STACK_DEADLINE_CYC = SFR_STACK_DEADLINE_MS * 1000 * SFR_CLK_MHZ;
    localparam int SFR_READY_DEADLINE_CYC = SFR_READY_DEADLINE_MS * 1000 * SFR_CLK_MHZ;
    localparam int SFR_TIMER_W = 24;

    // Reset values.
    localparam logic [31:0] SFR_RDATA_RST = 32'h0000_0000;
    localparam logic [SFR_TIMER_W-1:0] SFR_TIMER_RST = 24'h00_0000;

    typedef enum logic [3:0] {
        SFR_WAIT = 4'h0,
        SFR_SAMPLE = 4'h1,
        SFR_INIT = 4'h3,
        SFR_UNLOCK = 4'h2,
        SFR_PLL = 4'h6,
        SFR_MSMB = 4'h7,
        SFR_SSMB = 4'h5,
        SFR_STACK = 4'h4,
        SFR_HALT = 4'hC,
        SFR_RELOCK = 4'hD,
        SFR_RUN = 4'hF
    } sfr_state_t;

    // Captured boot configuration vector.
    typedef struct packed {
        logic [3:0] merge;
        logic halt;
        logic [3:0] slave_addr;
        logic [3:0] mode;
        logic slow;
        logic [3:0] eeprom_addr;
    } sfr_boot_t;

    localparam sfr_boot_t SFR_BOOT_RST = '0;

endpackage

// ### sfr_seq.sv
// Switch fundamental reset sequencer with an APB register slave.
// Assumes straps and handshake inputs are synchronous to pclk and that the
// slave SMBus bridge reaches the switch control register through APB.
//
// Function
// - Sampled merge straps fix merging of port pairs 8/9 through 14/15, unchangeable.
// - Reset-halt strap keeps device in reset with both SMBus interfaces active.
// - External master clears halt bit; device leaves halted state only then.
// - Own slave SMBus address takes strap bits 5 and 3 to 1.
// - Four-bit switch-mode strap sets operating mode, fixed after sampling.
// - Cold and warm fundamental resets run the identical sequence.
// - Global reset input assertion starts a fundamental reset at any time.
// - First step holds until the global reset input is negated.
// - On negation capture every boot strap once and hold it.
// - After sampling, every register is loaded with its default value.
// - After register init set the register-unlock bit in switch control.
// - Start PLL and SerDes init and proceed only after PLL lock.
// - Master SMBus uses sampled slow strap and EEPROM address bits 4 to 1.
// - After master SMBus setup release and initialize the slave SMBus.
// - Within 20 ms of negation release port stacks and start link training.
// - Within 100 ms of negation all ports accept and process TLPs.
// - Boot straps are sampled only in fundamental reset, ignored otherwise.
// - While halted, ports retry type 0 config requests and drop other TLPs.
// - Clear the register-unlock bit before normal operation begins.
//
// Our own choices: the APB slave port and the register addresses.
module sfr_seq
    import sfr_pkg::*;
#(
    parameter int STACK_DEADLINE_CYC = SFR_STACK_DEADLINE_CYC,
    parameter int READY_DEADLINE_CYC = SFR_READY_DEADLINE_CYC,
    parameter logic [6:0] SLAVE_ADDR_BASE = 7'h00,
    parameter logic [6:0] EEPROM_ADDR_BASE = 7'h00
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board reset and boot straps.
    input wire logic global_reset_n,
    input wire logic [3:0] merge_strap,
    input wire logic reset_halt_req,
    input wire logic [3:0] slave_bus_addr_strap,
    input wire logic [3:0] switch_mode_strap,
    input wire logic master_bus_slow_strap,
    input wire logic [3:0] master_bus_eeprom_addr_strap,
    // PLL and SerDes.
    input wire logic pll_lock,
    output logic pll_init,
    // SMBus interfaces.
    output logic master_bus_en,
    output logic master_bus_slow,
    output logic [6:0] master_bus_eeprom_addr,
    output logic slave_bus_rst_n,
    output logic [6:0] slave_bus_addr,
    // Port stacks.
    output logic [3:0] pair_merge_sel,
    output logic [3:0] switch_mode,
    output logic stack_rst_n,
    output logic quasi_reset,
    output logic ports_ready,
    output logic normal_op
);

    sfr_state_t state_q, state_d;
    sfr_boot_t boot_q, boot_d;
    logic unlock_q, unlock_d;
    logic halt_q, halt_d;
    logic stack_rel_q, stack_rel_d;
    logic ready_q, ready_d;
    logic [SFR_TIMER_W-1:0] timer_q, timer_d;
    logic [31:0] rdata_q, rdata_d;

    logic setup;
    logic access;
    logic wr_ctrl;
    logic past_stack;

    // Inserts strap bits 5 and 3 to 1 into a fixed slave address.
    function automatic logic [6:0] slave_addr_f(input logic [6:0] base, input logic [3:0] s);
        slave_addr_f = {base[6], s[3], base[4], s[2:0], base[0]};
    endfunction

    // Inserts strap bits 4 to 1 into a fixed EEPROM address.
    function automatic logic [6:0] eeprom_addr_f(input logic [6:0] base, input logic [3:0] s);
        eeprom_addr_f = {base[6:5], s, base[0]};
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_ctrl = access && pwrite && (paddr == SFR_CTRL_OFS);
    assign past_stack = (state_q == SFR_STACK) || (state_q == SFR_HALT) ||
                        (state_q == SFR_RELOCK) || (state_q == SFR_RUN);

    // Sequencer, captured straps and control bits.
    always_comb begin
        state_d = state_q;
        boot_d = boot_q;
        unlock_d = unlock_q;
        halt_d = halt_q;
        stack_rel_d = stack_rel_q;
        ready_d = ready_q;
        timer_d = timer_q;
        if (timer_q < SFR_TIMER_W'(READY_DEADLINE_CYC)) begin
            timer_d = timer_q + 1'b1;
        end
        case (state_q)
            SFR_WAIT: begin
                timer_d = SFR_TIMER_RST;
                if (global_reset_n) begin
                    state_d = SFR_SAMPLE;
                end
            end
            SFR_SAMPLE: begin
                // Straps are captured here and nowhere else.
                boot_d = '{merge: merge_strap, halt: reset_halt_req,
                           slave_addr: slave_bus_addr_strap, mode: switch_mode_strap,
                           slow: master_bus_slow_strap,
                           eeprom_addr: master_bus_eeprom_addr_strap};
                state_d = SFR_INIT;
            end
            SFR_INIT: begin
                unlock_d = 1'b0;
                halt_d = boot_q.halt;
                stack_rel_d = 1'b0;
                ready_d = 1'b0;
                state_d = SFR_UNLOCK;
            end
            SFR_UNLOCK: begin
                unlock_d = 1'b1;
                state_d = SFR_PLL;
            end
            SFR_PLL: begin
                if (pll_lock) begin
                    state_d = SFR_MSMB;
                end
            end
            SFR_MSMB: begin
                state_d = SFR_SSMB;
            end
            SFR_SSMB: begin
                state_d = SFR_STACK;
            end
            SFR_STACK: begin
                stack_rel_d = 1'b1;
                state_d = SFR_HALT;
            end
            SFR_HALT: begin
                if (!halt_q) begin
                    state_d = SFR_RELOCK;
                end
            end
            SFR_RELOCK: begin
                unlock_d = 1'b0;
                state_d = SFR_RUN;
            end
            SFR_RUN: begin
                state_d = SFR_RUN;
            end
            default: begin
                state_d = SFR_WAIT;
            end
        endcase
        // The deadline releases the stacks even if PLL lock is late.
        if (state_q != SFR_WAIT && timer_q >= SFR_TIMER_W'(STACK_DEADLINE_CYC - 2)) begin
            stack_rel_d = 1'b1;
        end
        if (stack_rel_q && timer_q >= SFR_TIMER_W'(READY_DEADLINE_CYC - 2)) begin
            ready_d = 1'b1;
        end
        // Write one to the halt bit clears it; the sequencer never sets it after INIT.
        if (wr_ctrl && pwdata[SFR_HALT_BIT] && state_q != SFR_INIT) begin
            halt_d = 1'b0;
        end
        // Any assertion of the global reset restarts the same sequence.
        if (!global_reset_n) begin
            state_d = SFR_WAIT;
            unlock_d = 1'b0;
            halt_d = 1'b0;
            stack_rel_d = 1'b0;
            ready_d = 1'b0;
            timer_d = SFR_TIMER_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SFR_WAIT;
            boot_q <= SFR_BOOT_RST;
            unlock_q <= 1'b0;
            halt_q <= 1'b0;
            stack_rel_q <= 1'b0;
            ready_q <= 1'b0;
            timer_q <= SFR_TIMER_RST;
        end else begin
            state_q <= state_d;
            boot_q <= boot_d;
            unlock_q <= unlock_d;
            halt_q <= halt_d;
            stack_rel_q <= stack_rel_d;
            ready_q <= ready_d;
            timer_q <= timer_d;
        end
    end

    // Read data is latched in the setup cycle and shown during access.
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = SFR_RDATA_RST;
            case (paddr)
                SFR_CTRL_OFS: begin
                    rdata_d[SFR_UNLOCK_BIT] = unlock_q;
                    rdata_d[SFR_HALT_BIT] = halt_q;
                end
                SFR_BOOT_OFS: begin
                    rdata_d[$bits(sfr_boot_t)-1:0] = boot_q;
                end
                SFR_SEQ_OFS: begin
                    rdata_d[SFR_SEQ_STATE_LSB +: 4] = state_q;
                    rdata_d[SFR_SEQ_PLL_BIT] = pll_lock;
                    rdata_d[SFR_SEQ_STACK_BIT] = stack_rel_q;
                    rdata_d[SFR_SEQ_READY_BIT] = ready_q;
                    rdata_d[SFR_SEQ_QUASI_BIT] = quasi_reset;
                    rdata_d[SFR_SEQ_RUN_BIT] = normal_op;
                end
                default: begin
                    rdata_d = SFR_RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= SFR_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = access;
    assign pslverr = access && (paddr != SFR_CTRL_OFS) && (paddr != SFR_BOOT_OFS) &&
                     (paddr != SFR_SEQ_OFS);

    // Outputs derived from the registered sequence state, captured straps and control bits.
    assign pll_init = (state_q == SFR_PLL);
    assign master_bus_en = (state_q != SFR_WAIT) && (state_q != SFR_SAMPLE) &&
                           (state_q != SFR_INIT) && (state_q != SFR_UNLOCK) &&
                           (state_q != SFR_PLL);
    assign master_bus_slow = boot_q.slow;
    assign master_bus_eeprom_addr = eeprom_addr_f(EEPROM_ADDR_BASE, boot_q.eeprom_addr);
    assign slave_bus_rst_n = master_bus_en && (state_q != SFR_MSMB);
    assign slave_bus_addr = slave_addr_f(SLAVE_ADDR_BASE, boot_q.slave_addr);
    assign pair_merge_sel = boot_q.merge;
    assign switch_mode = boot_q.mode;
    assign stack_rst_n = stack_rel_q;
    assign quasi_reset = stack_rel_q && (state_q != SFR_RUN) &&
                         (state_q != SFR_RELOCK);
    assign ports_ready = ready_q;
    assign normal_op = (state_q == SFR_RUN) && ready_q;

    // Assertions.
    AST_MERGE_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != SFR_SAMPLE) |=> $stable(boot_q))
        else $error("Straps changed outside the sample step.");
    AST_HALT_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_HALT && halt_q) |=> (state_q == SFR_HALT || !global_reset_n ||
        !$past(global_reset_n)))
        else $error("Left halted state while halt bit set.");
    AST_HALT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_HALT && !halt_q && global_reset_n) |=> (state_q == SFR_RELOCK))
        else $error("Halt clear did not release the sequence.");
    AST_SLAVE_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        {slave_bus_addr[5], slave_bus_addr[3:1]} == boot_q.slave_addr)
        else $error("Slave address does not follow strap.");
    AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        !global_reset_n |=> (state_q == SFR_WAIT && !stack_rst_n && !unlock_q))
        else $error("Global reset did not restart the sequence.");
    AST_WAIT_NEG: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_WAIT && global_reset_n) |=> (state_q == SFR_SAMPLE))
        else $error("Sequence did not leave first step on negation.");
    AST_WAIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_WAIT && !global_reset_n) |=> (state_q == SFR_WAIT))
        else $error("Sequence left first step while global reset held.");
    AST_UNLOCK_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_UNLOCK && global_reset_n) |=> (unlock_q && state_q == SFR_PLL))
        else $error("Unlock bit not set after init.");
    AST_PLL_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_PLL && !pll_lock && global_reset_n) |=> (state_q == SFR_PLL))
        else $error("Advanced without PLL lock.");
    AST_SMB_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(slave_bus_rst_n) |-> $past(master_bus_en))
        else $error("Slave SMBus released before master set up.");
    AST_STACK_DEADLINE: assert property (@(posedge pclk) disable iff (!presetn)
        (global_reset_n && state_q != SFR_WAIT &&
         timer_q >= SFR_TIMER_W'(STACK_DEADLINE_CYC)) |-> stack_rst_n)
        else $error("Stack reset held past its deadline.");
    AST_READY_DEADLINE: assert property (@(posedge pclk) disable iff (!presetn)
        (global_reset_n && state_q != SFR_WAIT &&
         timer_q >= SFR_TIMER_W'(READY_DEADLINE_CYC)) |-> ports_ready)
        else $error("Ports not ready by deadline.");
    AST_READY_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        ports_ready |-> stack_rst_n)
        else $error("Ports ready while stacks held in reset.");
    AST_RELOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (normal_op) |-> !unlock_q)
        else $error("Normal operation with register unlock set.");
    AST_QUASI: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_HALT && halt_q && stack_rst_n) |-> quasi_reset)
        else $error("Halted ports not in quasi-reset.");
    AST_RESET_SAME: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_WAIT) |-> (!stack_rst_n && !unlock_q && !quasi_reset && !normal_op))
        else $error("First step entered with state left from an earlier run.");
    AST_STRAP_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_SAMPLE) |=> (boot_q.merge == $past(merge_strap) &&
        boot_q.mode == $past(switch_mode_strap) && boot_q.halt == $past(reset_halt_req)))
        else $error("Boot straps not captured in the sample step.");
    AST_INIT_DEFAULTS: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_INIT && global_reset_n) |=>
        (!unlock_q && !stack_rst_n && !ports_ready && state_q == SFR_UNLOCK))
        else $error("Registers not at defaults after init.");
    AST_LOCK_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(master_bus_en) |-> $past(pll_lock))
        else $error("Master SMBus started before PLL lock.");
    AST_MSMB_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
        master_bus_en |-> (master_bus_slow == boot_q.slow &&
        master_bus_eeprom_addr[4:1] == boot_q.eeprom_addr))
        else $error("Master SMBus setup does not follow straps.");
    AST_STACK_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        (past_stack && state_q != SFR_STACK) |-> stack_rst_n)
        else $error("Late sequence step reached with port stacks held.");
    AST_RUN_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SFR_RELOCK && global_reset_n) |=> (state_q == SFR_RUN && !unlock_q))
        else $error("Unlock bit not cleared on the way to normal operation.");
    AST_MODE_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != SFR_SAMPLE) |=> $stable(switch_mode))
        else $error("Switch mode changed after sampling.");

endmodule

// ### tb_switch_fundamental_reset_seq.sv
// Self-checking bench for the fundamental reset sequencer.
// Assumes sfr_pkg, sfr_seq and sfr_board_model are compiled before it.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module tb_switch_fundamental_reset_seq;
    timeunit 1ns;
    timeprecision 1ps;
    import sfr_pkg::*;
    localparam int STACK_CYC = 200;
    localparam int READY_CYC = 1000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic global_reset_n, reset_halt_req, master_bus_slow_strap, pll_lock, pll_init;
    logic [3:0] merge_strap, slave_bus_addr_strap, switch_mode_strap, eeprom_strap;
    logic master_bus_en, master_bus_slow, slave_bus_rst_n, stack_rst_n, quasi_reset;
    logic ports_ready, normal_op, hold_reset, block_lock;
    logic [6:0] master_bus_eeprom_addr, slave_bus_addr;
    logic [3:0] pair_merge_sel, switch_mode;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;

    sfr_seq #(.STACK_DEADLINE_CYC(STACK_CYC), .READY_DEADLINE_CYC(READY_CYC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_reset_n(global_reset_n), .merge_strap(merge_strap),
        .reset_halt_req(reset_halt_req), .slave_bus_addr_strap(slave_bus_addr_strap),
        .switch_mode_strap(switch_mode_strap), .master_bus_slow_strap(master_bus_slow_strap),
        .master_bus_eeprom_addr_strap(eeprom_strap), .pll_lock(pll_lock),
        .pll_init(pll_init), .master_bus_en(master_bus_en),
        .master_bus_slow(master_bus_slow), .master_bus_eeprom_addr(master_bus_eeprom_addr),
        .slave_bus_rst_n(slave_bus_rst_n), .slave_bus_addr(slave_bus_addr),
        .pair_merge_sel(pair_merge_sel), .switch_mode(switch_mode),
        .stack_rst_n(stack_rst_n), .quasi_reset(quasi_reset), .ports_ready(ports_ready),
        .normal_op(normal_op));

    sfr_board_model board (
        .pclk(pclk), .presetn(presetn), .hold_reset(hold_reset), .block_lock(block_lock),
        .pll_init(pll_init), .global_reset_n(global_reset_n), .pll_lock(pll_lock));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    // One APB transfer; read data and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_state(input logic [3:0] code, input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, SFR_SEQ_OFS, 32'h0);
            n++;
        end while (rd[3:0] !== code && n < lim);
    endtask

    task automatic wait_until(input int t);
        while (cyc < t) @(posedge pclk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        merge_strap = 4'hA;
        reset_halt_req = 1'b1;
        slave_bus_addr_strap = 4'h5;
        switch_mode_strap = 4'h9;
        master_bus_slow_strap = 1'b1;
        eeprom_strap = 4'h6;
        hold_reset = 1'b1;
        block_lock = 1'b1;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SFR_CTRL_OFS, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        `CHK("mapped ok", 1'h0, err)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("unmapped err", 1'h1, err)
        apb(1'b0, SFR_SEQ_OFS, 32'h0);
        `CHK("held state", 4'h0, rd[3:0])
        $display("test registers done");
        hold_reset <= 1'b0;
        t0 = cyc;
        wait_state(4'h6, 20);
        `CHK("pll state", 4'h6, rd[3:0])
        merge_strap <= 4'h5;
        reset_halt_req <= 1'b0;
        slave_bus_addr_strap <= 4'hB;
        switch_mode_strap <= 4'h3;
        master_bus_slow_strap <= 1'b0;
        eeprom_strap <= 4'h9;
        apb(1'b0, SFR_CTRL_OFS, 32'h0);
        `CHK("unlock set", 1'h1, rd[SFR_UNLOCK_BIT])
        wait_until(t0 + STACK_CYC + 5);
        `CHK("stack deadline", 1'h1, stack_rst_n)
        `CHK("pll init", 1'h1, pll_init)
        `CHK("master before lock", 1'h0, master_bus_en)
        block_lock <= 1'b0;
        wait_state(4'hC, 40);
        `CHK("halt state", 4'hC, rd[3:0])
        `CHK("master on", 1'h1, master_bus_en)
        `CHK("slave on", 1'h1, slave_bus_rst_n)
        `CHK("quasi", 1'h1, quasi_reset)
        `CHK("slow", 1'h1, master_bus_slow)
        `CHK("eeprom addr", 4'h6, master_bus_eeprom_addr[4:1])
        `CHK("slave addr", 7'h0A, slave_bus_addr)
        `CHK("merge", 4'hA, pair_merge_sel)
        `CHK("mode", 4'h9, switch_mode)
        apb(1'b0, SFR_BOOT_OFS, 32'h0);
        `CHK("boot", {14'h0, 4'hA, 1'h1, 4'h5, 4'h9, 1'h1, 4'h6}, rd)
        wait_until(t0 + READY_CYC + 5);
        `CHK("ready", 1'h1, ports_ready)
        `CHK("halted op", 1'h0, normal_op)
        apb(1'b0, SFR_CTRL_OFS, 32'h0);
        `CHK("halt bit", 32'h3, rd)
        apb(1'b1, SFR_CTRL_OFS, 32'h2);
        wait_state(4'hF, 20);
        `CHK("run state", 4'hF, rd[3:0])
        apb(1'b0, SFR_CTRL_OFS, 32'h0);
        `CHK("unlock clear", 32'h0, rd)
        `CHK("normal", 1'h1, normal_op)
        `CHK("quasi off", 1'h0, quasi_reset)
        $display("test cold sequence done");
        hold_reset <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("warm stack", 1'h0, stack_rst_n)
        `CHK("warm op", 1'h0, normal_op)
        apb(1'b0, SFR_SEQ_OFS, 32'h0);
        `CHK("warm wait", 4'h0, rd[3:0])
        hold_reset <= 1'b0;
        wait_state(4'hF, 600);
        `CHK("warm run", 4'hF, rd[3:0])
        apb(1'b0, SFR_BOOT_OFS, 32'h0);
        `CHK("warm boot", {14'h0, 4'h5, 1'h0, 4'hB, 4'h3, 1'h0, 4'h9}, rd)
        `CHK("warm mode", 4'h3, switch_mode)
        `CHK("warm slave addr", 7'h26, slave_bus_addr)
        $display("test warm sequence done");
        end_sim();
    end
endmodule
